// [pkg/tps_defs.svh]
// Constants of the test port sequencer: state codes, widths, reset and capture values
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH

// ****************************************
// State codes as seen on the state port
// ****************************************
`define TPS_CODE_DATA_EXIT_TWO 4'h0
`define TPS_CODE_DATA_EXIT_ONE 4'h1
`define TPS_CODE_DATA_SHIFT 4'h2
`define TPS_CODE_DATA_PAUSE 4'h3
`define TPS_CODE_INSTR_SCAN_SELECT 4'h4
`define TPS_CODE_DATA_UPDATE 4'h5
`define TPS_CODE_DATA_CAPTURE 4'h6
`define TPS_CODE_DATA_SCAN_SELECT 4'h7
`define TPS_CODE_INSTR_EXIT_TWO 4'h8
`define TPS_CODE_INSTR_EXIT_ONE 4'h9
`define TPS_CODE_INSTR_SHIFT 4'hA
`define TPS_CODE_INSTR_PAUSE 4'hB
`define TPS_CODE_RUN_IDLE 4'hC
`define TPS_CODE_INSTR_UPDATE 4'hD
`define TPS_CODE_INSTR_CAPTURE 4'hE
`define TPS_CODE_LOGIC_RESET 4'hF

// ****************************************
// Instruction and bypass registers
// ****************************************
`define TPS_IR_WIDTH 7
`define TPS_IR_RESET 7'h60
`define TPS_IR_CAPTURE 7'h01
`define TPS_BYPASS_CAPTURE 1'h0

`endif

// [pkg/tps_pkg.sv]
// Types shared by the test port sequencer modules
`include "tps_defs.svh"

package tps_pkg;

    // ****************************************
    // Controller states
    // ****************************************
    typedef enum logic [3:0] {
        TPS_LOGIC_RESET,
        TPS_RUN_IDLE,
        TPS_DATA_SCAN_SELECT,
        TPS_DATA_CAPTURE,
        TPS_DATA_SHIFT,
        TPS_DATA_EXIT_ONE,
        TPS_DATA_PAUSE,
        TPS_DATA_EXIT_TWO,
        TPS_DATA_UPDATE,
        TPS_INSTR_SCAN_SELECT,
        TPS_INSTR_CAPTURE,
        TPS_INSTR_SHIFT,
        TPS_INSTR_EXIT_ONE,
        TPS_INSTR_PAUSE,
        TPS_INSTR_EXIT_TWO,
        TPS_INSTR_UPDATE
    } tps_state_t;

    // Strobes to an external data register, test clock domain
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
    } tps_scan_t;

    // Test clock domain state
    typedef struct packed {
        tps_state_t state;
        logic run;
        logic toggle;
    } tps_link_t;

    // System clock domain state
    typedef struct packed {
        logic tog_stable;
        logic tog_seen;
        logic run_stable;
        logic [`TPS_IR_WIDTH-1:0] instr;
    } tps_sys_t;

    function automatic logic [3:0] tps_code(input tps_state_t s);
        case (s)
            TPS_DATA_EXIT_TWO: tps_code = `TPS_CODE_DATA_EXIT_TWO;
            TPS_DATA_EXIT_ONE: tps_code = `TPS_CODE_DATA_EXIT_ONE;
            TPS_DATA_SHIFT: tps_code = `TPS_CODE_DATA_SHIFT;
            TPS_DATA_PAUSE: tps_code = `TPS_CODE_DATA_PAUSE;
            TPS_INSTR_SCAN_SELECT: tps_code = `TPS_CODE_INSTR_SCAN_SELECT;
            TPS_DATA_UPDATE: tps_code = `TPS_CODE_DATA_UPDATE;
            TPS_DATA_CAPTURE: tps_code = `TPS_CODE_DATA_CAPTURE;
            TPS_DATA_SCAN_SELECT: tps_code = `TPS_CODE_DATA_SCAN_SELECT;
            TPS_INSTR_EXIT_TWO: tps_code = `TPS_CODE_INSTR_EXIT_TWO;
            TPS_INSTR_EXIT_ONE: tps_code = `TPS_CODE_INSTR_EXIT_ONE;
            TPS_INSTR_SHIFT: tps_code = `TPS_CODE_INSTR_SHIFT;
            TPS_INSTR_PAUSE: tps_code = `TPS_CODE_INSTR_PAUSE;
            TPS_RUN_IDLE: tps_code = `TPS_CODE_RUN_IDLE;
            TPS_INSTR_UPDATE: tps_code = `TPS_CODE_INSTR_UPDATE;
            TPS_INSTR_CAPTURE: tps_code = `TPS_CODE_INSTR_CAPTURE;
            default: tps_code = `TPS_CODE_LOGIC_RESET;
        endcase
    endfunction

endpackage

// [testbench/testbench.sv]
// Self-checking bench for the test port sequencer
`include "tps_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 1'b0;
    logic RST_N, TCK, TRST_N, TMS, TDI, TDO, TDO_OE, DR_SELECT, DR_SI, DR_SO, TEST_RUN;
    logic [3:0] STATE_CODE;
    tps_pkg::tps_scan_t DR_SCAN;
    logic [`TPS_IR_WIDTH-1:0] INSTR_TCK, INSTR;
    logic [1:0] seen;
    int num_errors = 0;
    int compares = 0;
    tps_top dut (.CLK, .RST_N, .TCK, .TRST_N, .TMS, .TDI, .TDO, .TDO_OE, .STATE_CODE, .DR_SCAN,
        .DR_SELECT, .DR_SI, .DR_SO, .INSTR_TCK, .INSTR, .TEST_RUN);
    tps_tester tester (.TCK, .TMS, .TDI, .TDO, .TDO_OE, .DR_SCAN, .DR_SI, .DR_SO);
    initial begin
        forever #12.5 CLK = ~CLK;
    end
    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input logic tms, input logic tdi);
        tester.tck_bit(tms, tdi, seen);
    endtask
    // Offset keeps the two clocks out of phase
    task automatic wait_sys(input logic [6:0] v, input logic run);
        int k;
        for (k = 0; k < 40 && !(INSTR === v && TEST_RUN === run); k++) @(negedge CLK);
        if (k == 40) begin
            num_errors++;
            tally_and_finish();
        end
        #4.1;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic walk_states();
        logic [43:0] tms_seq;
        logic [175:0] codes;
        tms_seq = 44'h912EB625EB7;
        codes = 176'hFCC7622133_0215761305_C74EAA9BB8_A9D74E9B8D_C74F;
        for (int i = 43; i >= 0; i--) begin
            step(tms_seq[i], 1'b1);
            check_vec(8'(STATE_CODE), 8'(codes[4*i+:4]));
        end
    endtask
    task automatic scan_dr(input logic [7:0] din, input logic [7:0] dexp, input logic sel);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        check_vec(8'(DR_SELECT), 8'(sel));
        for (int i = 0; i < 8; i++) begin
            step(i == 7, din[i]);
            check_vec(8'(seen), {6'h00, 1'b1, dexp[i]});
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        check_vec(8'(STATE_CODE), 8'h0C);
    endtask
    task automatic load_instr(input logic [6:0] v, input logic run);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < 7; i++) begin
            // First bit in ends at the top stage, so send the high bit first
            step(i == 6, v[6 - i]);
            check_vec(8'(seen), {6'h00, 1'b1, i == 6});
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        check_vec(8'(INSTR_TCK), 8'(v));
        step(1'b0, 1'b1);
        wait_sys(v, run);
        check_vec({INSTR, TEST_RUN}, {v, run});
        step(1'b1, 1'b1);
        wait_sys(v, 1'b0);
        check_vec(8'(TEST_RUN), 8'h00);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic trst_midscan();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        @(posedge CLK) TRST_N <= 1'b0;
        @(negedge CLK);
        check_vec(8'({TDO_OE, STATE_CODE}), 8'h0F);
        step(1'b0, 1'b1);
        check_vec(8'(STATE_CODE), 8'h0F);
        check_vec(8'(INSTR_TCK), 8'h60);
        @(posedge CLK) TRST_N <= 1'b1;
        #4.1;
        step(1'b0, 1'b1);
        check_vec(8'(STATE_CODE), 8'h0C);
    endtask
    initial begin
        RST_N = 1'b0;
        TRST_N = 1'b0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        TRST_N <= 1'b1;
        @(negedge CLK);
        #4.1;
        check_vec(8'(STATE_CODE), 8'h0F);
        check_vec({INSTR, TEST_RUN}, 8'hC0);
        check_vec(8'(INSTR_TCK), 8'h60);
        walk_states();
        scan_dr(8'hC5, 8'h8A, 1'b0);
        load_instr(7'h05, 1'b1);
        load_instr(7'h00, 1'b0);
        scan_dr(8'hC5, 8'h59, 1'b1);
        check_vec(8'(tester.ext_latch), 8'h03);
        trst_midscan();
        tally_and_finish();
    end
endmodule // testbench
bind tps_top tps_monitor mon (.CLK, .RST_N, .TCK, .TRST_N, .TMS, .TDI, .TDO, .TDO_OE, .STATE_CODE,
    .DR_SCAN, .DR_SELECT, .DR_SI, .DR_SO, .INSTR_TCK, .INSTR, .TEST_RUN);

// [testbench/tps_monitor.sv]
// Port checks for the test port sequencer
`include "tps_defs.svh"
module tps_monitor (
    input wire logic CLK, // System clock
    input wire logic RST_N, // System reset
    input wire logic TCK, // Test clock
    input wire logic TRST_N, // Test reset
    input wire logic TMS, // Mode select
    input wire logic TDI, // Data in
    input wire logic TDO, // Data out
    input wire logic TDO_OE, // Out enable
    input wire logic [3:0] STATE_CODE, // State
    input wire tps_pkg::tps_scan_t DR_SCAN, // Strobes
    input wire logic DR_SELECT, // External selected
    input wire logic DR_SI, // To external
    input wire logic DR_SO, // From external
    input wire logic [`TPS_IR_WIDTH-1:0] INSTR_TCK, // Latch
    input wire logic [`TPS_IR_WIDTH-1:0] INSTR, // System copy
    input wire logic TEST_RUN // Self test
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Test clock domain
    // ****
    data_exit_two_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'h0 |=> STATE_CODE == ($past(TMS) ? 4'h5 : 4'h2)) else $error("data exit two step");
    data_exit_one_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'h1 |=> STATE_CODE == ($past(TMS) ? 4'h5 : 4'h3)) else $error("data exit one step");
    data_pause_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'h3 |=> STATE_CODE == ($past(TMS) ? 4'h0 : 4'h3)) else $error("data pause step");
    instr_select_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'h4 |=> STATE_CODE == ($past(TMS) ? 4'hF : 4'hE)) else $error("instr select step");
    data_select_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'h7 |=> STATE_CODE == ($past(TMS) ? 4'h4 : 4'h6)) else $error("data select step");
    instr_pause_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'hB |=> STATE_CODE == ($past(TMS) ? 4'h8 : 4'hB)) else $error("instr pause step");
    run_idle_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'hC |=> STATE_CODE == ($past(TMS) ? 4'h7 : 4'hC)) else $error("run idle step");
    logic_reset_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        STATE_CODE == 4'hF |=> STATE_CODE == ($past(TMS) ? 4'hF : 4'hC) && INSTR_TCK == `TPS_IR_RESET)
        else $error("logic reset step");
    test_reset_a: assert property (@(posedge TCK)
        !TRST_N |-> STATE_CODE == 4'hF) else $error("reset state not held");
    data_strobes_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        DR_SCAN == ({STATE_CODE == 4'h6, STATE_CODE == 4'h2, STATE_CODE == 4'h5} & {3{DR_SELECT}}))
        else $error("data strobes wrong");
    out_enable_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        TDO_OE == (STATE_CODE inside {4'h2, 4'hA})) else $error("output enable wrong");
    latch_change_a: assert property (@(posedge TCK) disable iff (!TRST_N)
        $past(TRST_N) && $changed(INSTR_TCK) |-> $past(STATE_CODE) inside {4'hD, 4'hF})
        else $error("latch changed outside update");
    // ****
    // System clock domain
    // ****
    self_test_a: assert property (@(posedge CLK) disable iff (!RST_N)
        TEST_RUN |-> INSTR inside {[7'h03:7'h07]}) else $error("test run without self test");
endmodule // tps_monitor

// [testbench/tps_tester.sv]
// Boundary-scan tester and a four-bit external data register
module tps_tester (
    output logic TCK, // Test clock
    output logic TMS, // Mode select
    output logic TDI, // Data in
    input wire logic TDO, // Data out
    input wire logic TDO_OE, // Out enable
    input wire tps_pkg::tps_scan_t DR_SCAN, // Strobes
    input wire logic DR_SI, // Serial in
    output logic DR_SO // Serial out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] ext_reg = 4'h0;
    logic [3:0] ext_latch = 4'h0;
    initial begin
        TCK = 1'b1;
        TMS = 1'b1;
        TDI = 1'b1;
    end
    assign DR_SO = ext_reg[3];
    always @(posedge TCK) begin
        if (DR_SCAN.capture) begin
            ext_reg <= 4'h9;
        end else if (DR_SCAN.shift) begin
            ext_reg <= {ext_reg[2:0], DR_SI};
        end
        if (DR_SCAN.update) begin
            ext_latch <= ext_reg;
        end
    end
    // One test clock; returns enable and data out seen before the rise
    task automatic tck_bit(input logic tms, input logic tdi, output logic [1:0] seen);
        TCK = 1'b0;
        TMS = tms;
        TDI = tdi;
        #62.5;
        seen = {TDO_OE, TDO};
        TCK = 1'b1;
        #62.5;
    endtask
endmodule // tps_tester

// [verilog/tps_shreg.sv]
// Scan register with capture, shift and optional update latch
module tps_shreg #(
    parameter int W = 7,
    parameter logic [W-1:0] CAP = '0,
    parameter logic [W-1:0] RSTV = '0,
    parameter bit HAS_LATCH = 1'b1
) (
    input wire logic clk, // Test clock
    input wire logic rst_n, // Test reset, active low
    input wire logic clear, // Return latch to its reset value
    input wire logic capture, // Parallel load
    input wire logic shift, // Shift one stage
    input wire logic update, // Copy stages into latch
    input wire logic si, // Serial in, into the low bit
    output logic so, // Serial out, the high bit
    output logic [W-1:0] latch // Parallel output latch
);
    typedef struct packed {
        logic [W-1:0] stage;
        logic [W-1:0] hold;
    } tps_shreg_t;

    tps_shreg_t r;
    tps_shreg_t next_r;

    always_comb begin
        next_r = r;
        if (capture) begin
            next_r.stage = CAP;
        end else if (shift) begin
            next_r.stage = W'({r.stage, si}); // R19
        end
        if (HAS_LATCH && clear) begin
            next_r.hold = RSTV;
        end else if (HAS_LATCH && update) begin
            next_r.hold = r.stage;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= {CAP, RSTV};
        end else begin
            r <= next_r;
        end
    end

    assign so = r.stage[W-1];
    assign latch = r.hold;
endmodule // tps_shreg

// [verilog/tps_sync.sv]
// Three-stage synchroniser into the system clock
module tps_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [W-1:0] d, // Level from the other domain
    output logic [W-1:0] s2, // Second stage
    output logic [W-1:0] s3 // Third stage
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } tps_sync_t;

    tps_sync_t r;
    tps_sync_t next_r;

    always_comb begin
        next_r.s1 = d;
        // First stage feeds only the second
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign s2 = r.s2;
    assign s3 = r.s3;
endmodule // tps_sync

// [verilog/tps_top.sv]
// Test port sequencer: sixteen-state controller, instruction and bypass registers
// How it works
// R1: Synchronous state machine steered by mode-select on each rising test clock.
// R2: Data exit two, code 0, goes to update on 1, shift on 0.
// R3: Data exit one, code 1, goes to update on 1, pause on 0.
// R4: Data shift, code 2, moves selected register toward serial out each edge.
// R5: Data pause, code 3, holds on 0, goes to data exit two on 1.
// R6: Instruction scan select, code 4, transient; 0 starts instruction scan.
// R7: Data update, code 5, copies stages into the output latch.
// R8: Data capture, code 6, parallel-loads the selected data register.
// R9: Data scan select, code 7, transient; 0 starts data register scan.
// R10: Instruction exit two, code 8, goes to update on 1, shift on 0.
// R11: Instruction exit one, code 9, goes to update on 1, pause on 0.
// R12: Instruction shift, code A, moves instruction register toward serial out.
// R13: Instruction pause, code B, holds on 0, goes to instruction exit two on 1.
// R14: Run/idle, code C, runs selected internal test, stays on 0.
// R15: Instruction update, code D, copies instruction stages into latch.
// R16: Instruction capture, code E, loads the instruction capture value.
// R17: Logic reset, code F, disables test logic, selects bypass, stays on 1.
// R18: Seven-bit instruction register selects the test or data register.
// R19: Test data in enters the low bit on the rising edge.
// R20: High bit drives test data out on falling edge, released outside scans.
// R21: Test reset low forces logic reset whatever mode-select does.
// R22: Tester stops the test clock only while it is high.
// R23: Standard transitions among reset, run/idle and the two select states.
// R24: Capture, exit and update transitions as in the standard diagram.
// R25: Tester changes mode-select and data in only while test clock is low.
`include "tps_defs.svh"
module tps_top (
    input wire logic CLK, // System clock
    input wire logic RST_N, // System reset, active low
    input wire logic TCK, // Test clock
    input wire logic TRST_N, // Test reset, active low
    input wire logic TMS, // Mode select
    input wire logic TDI, // Test data in
    output logic TDO, // Test data out
    output logic TDO_OE, // Test data out enable
    output logic [3:0] STATE_CODE, // Controller state code
    output tps_pkg::tps_scan_t DR_SCAN, // External data register strobes
    output logic DR_SELECT, // External data register selected
    output logic DR_SI, // Serial data to external register
    input wire logic DR_SO, // Serial data from external register
    output logic [`TPS_IR_WIDTH-1:0] INSTR_TCK, // Instruction latch, test clock domain
    output logic [`TPS_IR_WIDTH-1:0] INSTR, // Instruction, system domain
    output logic TEST_RUN // Internal test running, system domain
);

    // ****************************************
    // Test clock domain
    // ****************************************
    tps_pkg::tps_link_t l;
    tps_pkg::tps_link_t next_l;
    logic [`TPS_IR_WIDTH-1:0] ir_latch;
    logic ir_so;
    logic bp_so;
    logic bypass_sel;
    logic self_test;
    logic in_reset;
    logic ir_capture;
    logic ir_shift;
    logic ir_update;
    logic dr_capture;
    logic dr_shift;
    logic dr_update;
    logic tdo_bit;
    logic tdo_drive;
    logic tdo_q;
    logic tdo_oe_q;

    assign in_reset = (l.state == tps_pkg::TPS_LOGIC_RESET);
    assign ir_capture = (l.state == tps_pkg::TPS_INSTR_CAPTURE); // R16
    assign ir_shift = (l.state == tps_pkg::TPS_INSTR_SHIFT); // R12
    assign ir_update = (l.state == tps_pkg::TPS_INSTR_UPDATE); // R15
    assign dr_capture = (l.state == tps_pkg::TPS_DATA_CAPTURE); // R8
    assign dr_shift = (l.state == tps_pkg::TPS_DATA_SHIFT); // R4
    assign dr_update = (l.state == tps_pkg::TPS_DATA_UPDATE); // R7

    // Bypass for 001xxxx, 01xxxxx and the reset code
    assign bypass_sel = (ir_latch[6:4] == 3'h1) || (ir_latch[6:5] == 2'h1) ||
                        (ir_latch == `TPS_IR_RESET); // R18
    assign self_test = (ir_latch[6:3] == 4'h0) && (ir_latch[2:0] >= 3'h3);

    always_comb begin
        next_l = l;
        // Mode select is stable here because it only moves while the clock is low
        case (l.state) // R1 R25
            tps_pkg::TPS_LOGIC_RESET: begin
                if (!TMS) begin
                    next_l.state = tps_pkg::TPS_RUN_IDLE; // R23
                end
            end
            tps_pkg::TPS_RUN_IDLE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_SCAN_SELECT; // R23
                end
            end
            tps_pkg::TPS_DATA_SCAN_SELECT: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_INSTR_SCAN_SELECT; // R23
                end else begin
                    next_l.state = tps_pkg::TPS_DATA_CAPTURE; // R9
                end
            end
            tps_pkg::TPS_DATA_CAPTURE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_EXIT_ONE; // R24
                end else begin
                    next_l.state = tps_pkg::TPS_DATA_SHIFT; // R24
                end
            end
            tps_pkg::TPS_DATA_SHIFT: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_EXIT_ONE; // R4
                end
            end
            tps_pkg::TPS_DATA_EXIT_ONE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_UPDATE; // R3
                end else begin
                    next_l.state = tps_pkg::TPS_DATA_PAUSE; // R3
                end
            end
            tps_pkg::TPS_DATA_PAUSE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_EXIT_TWO; // R5
                end
            end
            tps_pkg::TPS_DATA_EXIT_TWO: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_UPDATE; // R2
                end else begin
                    next_l.state = tps_pkg::TPS_DATA_SHIFT; // R2
                end
            end
            tps_pkg::TPS_DATA_UPDATE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_SCAN_SELECT; // R24
                end else begin
                    next_l.state = tps_pkg::TPS_RUN_IDLE; // R24
                end
            end
            tps_pkg::TPS_INSTR_SCAN_SELECT: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_LOGIC_RESET; // R23
                end else begin
                    next_l.state = tps_pkg::TPS_INSTR_CAPTURE; // R6
                end
            end
            tps_pkg::TPS_INSTR_CAPTURE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_INSTR_EXIT_ONE; // R24
                end else begin
                    next_l.state = tps_pkg::TPS_INSTR_SHIFT; // R24
                end
            end
            tps_pkg::TPS_INSTR_SHIFT: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_INSTR_EXIT_ONE; // R12
                end
            end
            tps_pkg::TPS_INSTR_EXIT_ONE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_INSTR_UPDATE; // R11
                end else begin
                    next_l.state = tps_pkg::TPS_INSTR_PAUSE; // R11
                end
            end
            tps_pkg::TPS_INSTR_PAUSE: begin
                // Goes to the instruction exit, not the data one
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_INSTR_EXIT_TWO; // R13
                end
            end
            tps_pkg::TPS_INSTR_EXIT_TWO: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_INSTR_UPDATE; // R10
                end else begin
                    next_l.state = tps_pkg::TPS_INSTR_SHIFT; // R10
                end
            end
            tps_pkg::TPS_INSTR_UPDATE: begin
                if (TMS) begin
                    next_l.state = tps_pkg::TPS_DATA_SCAN_SELECT; // R24
                end else begin
                    next_l.state = tps_pkg::TPS_RUN_IDLE; // R24
                end
            end
            default: begin
                next_l.state = tps_pkg::TPS_LOGIC_RESET;
            end
        endcase
        // Test starts on an edge spent in run/idle, so a freshly updated instruction decides
        next_l.run = (l.state == tps_pkg::TPS_RUN_IDLE) && (next_l.state == tps_pkg::TPS_RUN_IDLE) &&
                     self_test; // R14
        // Flag every change of the instruction latch made on a test clock edge for the system side
        if (ir_update || (in_reset && (ir_latch != `TPS_IR_RESET))) begin
            next_l.toggle = !l.toggle;
        end
    end

    always_ff @(posedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin
            l <= '{state: tps_pkg::TPS_LOGIC_RESET, run: 1'b0, toggle: 1'b0}; // R21
        end else begin
            l <= next_l;
        end
    end

    // ****************************************
    // Instruction and bypass registers
    // ****************************************
    tps_shreg #(
        .W(`TPS_IR_WIDTH),
        .CAP(`TPS_IR_CAPTURE),
        .RSTV(`TPS_IR_RESET),
        .HAS_LATCH(1'b1)
    ) u_instr (
        .clk(TCK),
        .rst_n(TRST_N),
        .clear(in_reset), // R17
        .capture(ir_capture),
        .shift(ir_shift),
        .update(ir_update),
        .si(TDI),
        .so(ir_so),
        .latch(ir_latch)
    );

    // Bypass has no latch and keeps its bit through logic reset
    tps_shreg #(
        .W(1),
        .CAP(`TPS_BYPASS_CAPTURE),
        .RSTV(`TPS_BYPASS_CAPTURE),
        .HAS_LATCH(1'b0)
    ) u_bypass (
        .clk(TCK),
        .rst_n(TRST_N),
        .clear(1'b0),
        .capture(dr_capture && bypass_sel),
        .shift(dr_shift && bypass_sel),
        .update(1'b0),
        .si(TDI),
        .so(bp_so),
        .latch()
    );

    // ****************************************
    // Serial output on the falling edge
    // ****************************************
    always_comb begin
        tdo_bit = 1'b0;
        tdo_drive = 1'b0;
        if (ir_shift) begin
            tdo_bit = ir_so;
            tdo_drive = 1'b1;
        end else if (dr_shift) begin
            tdo_bit = bypass_sel ? bp_so : DR_SO;
            tdo_drive = 1'b1;
        end
    end

    // A clock parked high leaves this flop settled after the last shift
    always_ff @(negedge TCK or negedge TRST_N) begin // R22
        if (!TRST_N) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_bit; // R20
            tdo_oe_q <= tdo_drive; // R20
        end
    end

    assign TDO = tdo_q;
    assign TDO_OE = tdo_oe_q;
    assign STATE_CODE = tps_pkg::tps_code(l.state);
    assign DR_SELECT = !bypass_sel;
    assign DR_SCAN.capture = dr_capture && !bypass_sel;
    assign DR_SCAN.shift = dr_shift && !bypass_sel;
    assign DR_SCAN.update = dr_update && !bypass_sel;
    assign DR_SI = TDI;
    assign INSTR_TCK = ir_latch;

    // ****************************************
    // System clock domain
    // ****************************************
    tps_pkg::tps_sys_t s;
    tps_pkg::tps_sys_t next_s;
    logic tog_s2;
    logic tog_s3;
    logic run_s2;
    logic run_s3;

    tps_sync #(
        .W(1)
    ) u_sync_toggle (
        .clk(CLK),
        .rst_n(RST_N),
        .d(l.toggle),
        .s2(tog_s2),
        .s3(tog_s3)
    );

    tps_sync #(
        .W(1)
    ) u_sync_run (
        .clk(CLK),
        .rst_n(RST_N),
        .d(l.run),
        .s2(run_s2),
        .s3(run_s3)
    );

    always_comb begin
        next_s = s;
        if (tog_s2 == tog_s3) begin
            next_s.tog_stable = tog_s3;
        end
        if (run_s2 == run_s3) begin
            next_s.run_stable = run_s3;
        end
        // Latch is held for many test clocks after a toggle, so the copy is safe
        if (s.tog_stable != s.tog_seen) begin
            next_s.tog_seen = s.tog_stable;
            next_s.instr = ir_latch;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '{tog_stable: 1'b0, tog_seen: 1'b0, run_stable: 1'b0, instr: `TPS_IR_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign INSTR = s.instr;
    assign TEST_RUN = s.run_stable;

endmodule // tps_top
